// ==== sim/scc_monitor.sv ====
// link checker for the sensor converter control pins
`default_nettype none
module scc_monitor (
	input wire logic sys_clk,            // system clock
	input wire logic reset_n,            // async reset, active low
	input wire logic sda_dev_oe,         // device pulls sda
	input wire logic shutdown_pin,       // shutdown request
	input wire logic interrupt_out_low,  // active-low irq
	input wire logic scl                 // resolved clock wire
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] per;    // cycles since scl rose
	logic [7:0] hi;     // cycles scl stayed high
	logic       scl_d;  // scl one cycle ago
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// saturating counters for rate and idle
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			per <= 8'hFF;
			hi <= 8'h00;
			scl_d <= 1'b1;
		end else begin
			scl_d <= scl;
			per <= (scl && !scl_d) ? 8'h00 : ((per == 8'hFF) ? per : per + 8'h01);
			hi <= !scl ? 8'h00 : ((hi == 8'hFF) ? hi : hi + 8'h01);
		end
	end
	chk_irq_idle_reset: assert property (
		$rose(reset_n) |-> interrupt_out_low[*3]) else $error("irq low after reset");
	chk_sd_irq_off: assert property (
		shutdown_pin[*6] |-> interrupt_out_low) else $error("irq low in shutdown");
	chk_sd_sda_quiet: assert property (
		shutdown_pin[*6] |-> !sda_dev_oe) else $error("device drives in shutdown");
	chk_ack_on_low: assert property (
		$rose(sda_dev_oe) |-> !scl) else $error("sda pulled while scl high");
	chk_release_on_low: assert property (
		$fell(sda_dev_oe) |-> !scl) else $error("sda released while scl high");
	chk_drive_hold: assert property (
		$rose(sda_dev_oe) |-> sda_dev_oe[*8]) else $error("sda drive too short");
	chk_drive_bound: assert property (
		$rose(sda_dev_oe) |-> ##[1:400] !sda_dev_oe) else $error("sda drive stuck");
	chk_link_rate: assert property (
		$rose(scl) |-> per >= 8'h18) else $error("scl period too short");
	chk_idle_quiet: assert property (
		hi > 8'h28 |-> !sda_dev_oe) else $error("device drives idle bus");
endmodule // scc_monitor
`default_nettype wire

// ==== sim/tb_sensor_converter_control_plane.sv ====
// self-checking bench: host and device joined over the link
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
	$display("BAD %0t got %h exp %h", $time, a, b); end end
module tb_sensor_converter_control_plane;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk, reset_n, cmd_wr, cmd_rd, in_sleep, converting;
	logic [2:0]  cmd_addr;
	logic [15:0] cmd_wdata, cmd_rdata, q, st;  // port data, last read, last status
	logic [3:0]  sensor_osc;                    // random sensor edges
	logic [2:0]  gf[4] = '{3'h1, 3'h4, 3'h5, 3'h3};  // filter codes
	int          mismatches, num_checks, n;
	int          mdl[int];                      // expected device registers
	scc_link_if link ();
	scc_host scc_host_inst (.sys_clk(sys_clk), .reset_n(reset_n), .cmd_addr(cmd_addr),
		.cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata),
		.link(link));
	scc_device #(.WAKE_CYCLES(32)) scc_device_inst (.sys_clk(sys_clk), .reset_n(reset_n),
		.sensor_osc(sensor_osc), .in_sleep(in_sleep), .converting(converting), .link(link));
	scc_monitor scc_monitor_inst (.sys_clk(sys_clk), .reset_n(reset_n),
		.sda_dev_oe(link.sda_dev_oe), .shutdown_pin(link.shutdown_pin),
		.interrupt_out_low(link.interrupt_out_low), .scl(link.scl));
	// 10 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	// oscillators toggle at random
	always @(posedge sys_clk) sensor_osc <= sensor_osc ^ 4'($urandom_range(0, 15));
	// model defaults after any reset
	task automatic mdl_rst();
		mdl = '{8'h18: 0, 8'h19: 0, 8'h1A: 16'h2801, 8'h1B: 16'h020F, 8'h1C: 0};
	endtask
	// one command port cycle, read data into q
	task automatic cmd(input logic wr, input logic [2:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		cmd_addr <= a;
		cmd_wdata <= d;
		cmd_wr <= wr;
		cmd_rd <= !wr;
		@(posedge sys_clk);
		cmd_wr <= 1'b0;
		cmd_rd <= 1'b0;
		@(negedge sys_clk);
		q = cmd_rdata;
	endtask
	// one register access over the link
	task automatic xfer(input logic rd, input logic [7:0] p, input logic [15:0] d);
		int k;
		cmd(1'b1, scc_pkg::HR_WDATA, d);
		cmd(1'b1, scc_pkg::HR_CMD, {7'h00, rd, p});
		@(posedge sys_clk);
		k = 0;
		do begin
			cmd(1'b0, scc_pkg::HR_STAT, 16'h0000);
			k++;
		end while (q[0] !== 1'b0 && k < 4000);
		if (k >= 4000) begin
			mismatches++;
			$display("BAD %0t link transfer timed out", $time);
		end
		st = q;
		cmd(1'b0, scc_pkg::HR_RDATA, 16'h0000);
	endtask
	// register write, mirrored in the model
	task automatic xw(input logic [7:0] p, input logic [15:0] d);
		xfer(1'b0, p, d);
		mdl[p] = d;
	endtask
	// verdict and end of run
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// hang guard
	initial begin
		#(100 * 90000);
		mismatches++;
		wrap_up();
	end
	// test sequence
	initial begin
		void'($urandom(73353));
		{reset_n, cmd_wr, cmd_rd, cmd_addr, cmd_wdata, sensor_osc} = '0;
		mismatches = 0;
		num_checks = 0;
		mdl_rst();
		repeat (5) @(posedge sys_clk);
		reset_n <= 1'b1;
		cmd(1'b0, scc_pkg::HR_STAT, 16'h0000);
		`CHK(q, 16'h0000)
		`CHK({in_sleep, converting, link.interrupt_out_low}, 3'b101)
		foreach (mdl[p]) begin
			xfer(1'b1, 8'(p), 16'h0000);
			`CHK(q, 16'(mdl[p]))
		end
		$display("test done: reset values");
		foreach (gf[i]) begin
			xw(scc_pkg::REG_SEQ, {13'h0041, gf[i]});
			xw(scc_pkg::REG_MASK, (16'($urandom) & 16'hC001) | 16'h0001);
			xfer(1'b1, scc_pkg::REG_SEQ, 16'h0000);
			`CHK(q, 16'(mdl[8'h1B]))
			xfer(1'b1, scc_pkg::REG_MASK, 16'h0000);
			`CHK(q, 16'(mdl[8'h19]))
		end
		$display("test done: register access");
		xw(scc_pkg::REG_RESET, 16'h8000);
		mdl_rst();
		repeat (10) @(posedge sys_clk);
		xfer(1'b1, scc_pkg::REG_RESET, 16'h0000);
		`CHK(q, 16'h0000)
		xfer(1'b1, scc_pkg::REG_MASK, 16'h0000);
		`CHK(q, 16'h0000)
		$display("test done: soft reset");
		xw(scc_pkg::REG_MASK, 16'hC001);
		cmd(1'b1, scc_pkg::HR_PINS, 16'h0003);
		repeat (10) @(posedge sys_clk);
		xfer(1'b1, scc_pkg::REG_MASK, 16'h0000);
		`CHK(st[1], 1'b1)
		cmd(1'b1, scc_pkg::HR_PINS, 16'h0002);
		mdl_rst();
		repeat (10) @(posedge sys_clk);
		xfer(1'b1, scc_pkg::REG_MASK, 16'h0000);
		`CHK({st[1], q}, 17'h00000)
		$display("test done: shutdown");
		xw(scc_pkg::REG_MASK, 16'h0001);
		xw(scc_pkg::REG_CONFIG, 16'h0801);
		`CHK(in_sleep, 1'b0)
		n = 0;
		while (link.interrupt_out_low !== 1'b0 && n < 3000) begin
			@(negedge sys_clk);
			n++;
		end
		`CHK(link.interrupt_out_low, 1'b0)
		`CHK(converting, 1'b1)
		xfer(1'b1, scc_pkg::REG_STATUS, 16'h0000);
		`CHK({q[6], q[3:0]}, 5'h1F)
		xw(scc_pkg::REG_CONFIG, 16'h2801);
		repeat (4) @(negedge sys_clk);
		`CHK({in_sleep, link.interrupt_out_low}, 2'b11)
		xfer(1'b1, scc_pkg::REG_STATUS, 16'h0000);
		`CHK(q, 16'h0000)
		$display("test done: wake and irq");
		xw(scc_pkg::REG_CONFIG, 16'h0881);
		n = 0;
		repeat (800) begin
			@(negedge sys_clk);
			n += int'(link.interrupt_out_low !== 1'b1);
		end
		`CHK(n, 0)
		$display("test done: irq disable");
		wrap_up();
	end
endmodule // tb_sensor_converter_control_plane
`default_nettype wire

// ==== verilog/scc_device.sv ====
// device end: i2c slave, registers, modes, interrupt and conversion
// How it works
// - irq only when unmasked and enabled
// - set status freezes until status/data read
// - status read clears errors and channel
// - sleep, por, shutdown, soft reset clear irq
// - disable bit holds irq pin high
// - filter code selects glitch filter width
// - power-up lands in sleep
// - sleep bit enters/leaves sleep, config kept
// - wait 16384 ref cycles after wake
// - sleep keeps i2c alive, no conversions
// - sleep entry clears results and errors
// - conversion mode samples every channel repeatedly
// - shutdown pin high resets all registers
// - shutdown: no conversions, no i2c answer
// - soft reset aborts and restores defaults
// - soft reset field reads zero
// - link at most 400 kbit/s
// - address byte then pointer byte
// - address 0x2A or 0x2B by pin
// - host keeps address pin steady
// - host reconfigures only while asleep
//
// The strobed register port is this design's own decision.
`default_nettype none
module scc_device #(
	parameter int unsigned WAKE_CYCLES = scc_pkg::WAKE_REF_CYCLES  // wake delay
) (
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	input  wire logic [3:0] sensor_osc,  // sensor oscillator inputs
	output logic            in_sleep,    // sleep mode active
	output logic            converting,  // conversion mode active
	scc_link_if.device      link
);
	typedef enum logic [2:0] {SL_IDLE = 3'b000, SL_ADDR = 3'b001, SL_PTR = 3'b010,
		SL_WR = 3'b011, SL_RD = 3'b100} scc_sl_t;

	logic        scl_s1, scl_s2, scl_s3;  // scl sync and history
	logic        sda_s1, sda_s2, sda_s3;  // sda sync and history
	logic        shut_s1, shut_s2;         // shutdown sync
	logic        asel_s1, asel_s2;         // address pin sync
	logic        asel;                     // latched address bit
	logic        scl_rise, scl_fall, i2c_start, i2c_stop;
	scc_sl_t     st;                       // slave state
	logic [3:0]  cnt;                      // bit count, 8 full, 9 ack
	logic [7:0]  shreg;                    // receive shifter
	logic        byte_hi;                  // second byte of word
	logic [7:0]  msb_hold;                 // first written byte
	logic [7:0]  ptr;                      // register pointer
	logic [15:0] tx_word;                  // word being sent
	logic [15:0] next_word;                // word after the pointer
	logic        wr_stb, rd_stb;           // register access pulses
	logic [7:0]  acc_addr;
	logic [15:0] wr_data;
	logic [15:0] err_mask, cfg, seq_cfg, status;
	logic [11:0] result [4];               // per channel result
	logic        soft_rst;                 // soft reset pulse
	logic        dev_clr;                  // return to defaults
	logic        sleep_now;
	logic [14:0] wake_cnt;
	logic [7:0]  win_cnt;
	logic        win_end;
	logic [11:0] edges [4];
	logic [3:0]  osc_f;                    // filtered oscillators
	logic [15:0] ev_bits;                  // new status events
	logic        irq_pend;

	// register read mux, used by load and reload
	function automatic logic [15:0] reg_read(input logic [7:0] a);
		case (a)
			scc_pkg::REG_DATA0:  reg_read = {4'h0, result[0]};
			scc_pkg::REG_DATA1:  reg_read = {4'h0, result[1]};
			scc_pkg::REG_DATA2:  reg_read = {4'h0, result[2]};
			scc_pkg::REG_DATA3:  reg_read = {4'h0, result[3]};
			scc_pkg::REG_STATUS: reg_read = status;
			scc_pkg::REG_MASK:   reg_read = err_mask;
			scc_pkg::REG_CONFIG: reg_read = cfg;
			scc_pkg::REG_SEQ:    reg_read = seq_cfg;
			default:             reg_read = 16'h0000;
		endcase
	endfunction

	// filter length in sys_clk cycles per code
	function automatic logic [2:0] gf_len(input logic [2:0] code);
		case (code)
			scc_pkg::GF_1MHZ:  gf_len = 3'h5;
			scc_pkg::GF_3M3HZ: gf_len = 3'h2;
			scc_pkg::GF_10MHZ: gf_len = 3'h1;
			scc_pkg::GF_33MHZ: gf_len = 3'h0;
			default:           gf_len = 3'h1;
		endcase
	endfunction

	function automatic logic is_data(input logic [7:0] a);
		is_data = (a == scc_pkg::REG_DATA0) || (a == scc_pkg::REG_DATA1) ||
			(a == scc_pkg::REG_DATA2) || (a == scc_pkg::REG_DATA3);
	endfunction

	assign scl_rise  = scl_s2 && !scl_s3;
	assign scl_fall  = !scl_s2 && scl_s3;
	assign i2c_start = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
	assign i2c_stop  = scl_s2 && scl_s3 && !sda_s3 && sda_s2;
	assign dev_clr   = shut_s2 || soft_rst;
	assign sleep_now = cfg[scc_pkg::CFG_SLEEP_BIT];
	assign in_sleep  = sleep_now;
	assign win_end   = converting && (win_cnt == 8'(scc_pkg::CONV_CYCLES - 1));
	// next word for auto-increment reads, follows every register
	always_comb next_word = reg_read(ptr + 8'h01);

	// pin synchronisers
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			{scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3} <= 6'h3F;
			{shut_s1, shut_s2, asel_s1, asel_s2} <= 4'h0;
		end else begin
			{scl_s1, scl_s2, scl_s3} <= {link.scl, scl_s1, scl_s2};
			{sda_s1, sda_s2, sda_s3} <= {link.sda, sda_s1, sda_s2};
			{shut_s1, shut_s2} <= {link.shutdown_pin, shut_s1};
			{asel_s1, asel_s2} <= {link.addr_sel, asel_s1};
		end
	end

	// address strap follows pin only while shut down, then held
	// pin assumed steady after exit
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			asel <= 1'b0;
		end else if (shut_s2) begin
			asel <= asel_s2;
		end
	end

	// i2c slave byte engine
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			st <= SL_IDLE;
			cnt <= 4'h0;
			shreg <= 8'h00;
			byte_hi <= 1'b0;
			msb_hold <= 8'h00;
			ptr <= 8'h00;
			tx_word <= 16'h0000;
			wr_stb <= 1'b0;
			rd_stb <= 1'b0;
			acc_addr <= 8'h00;
			wr_data <= 16'h0000;
			link.sda_dev_oe <= 1'b0;
		end else begin
			wr_stb <= 1'b0;
			rd_stb <= 1'b0;
			if (shut_s2 || i2c_stop) begin
				st <= SL_IDLE;
				link.sda_dev_oe <= 1'b0;
			end else if (i2c_start) begin
				st <= SL_ADDR;
				cnt <= 4'h0;
				link.sda_dev_oe <= 1'b0;
			end else if (st != SL_IDLE && scl_rise) begin
				if (cnt < 4'h8) begin
					shreg <= {shreg[6:0], sda_s2};
					cnt <= cnt + 4'h1;
				end else if (cnt == 4'h9 && st == SL_RD && sda_s2) begin
					st <= SL_IDLE;  // controller nack ends read
				end
			end else if (st != SL_IDLE && scl_fall) begin
				if (cnt == 4'h8) begin
					cnt <= 4'h9;
					case (st)
						SL_ADDR: begin
							if (shreg[7:1] == (asel ? scc_pkg::ADDR_PIN_HIGH
								: scc_pkg::ADDR_PIN_LOW)) begin
								link.sda_dev_oe <= 1'b1;
								byte_hi <= 1'b0;
								if (shreg[0]) begin
									st <= SL_RD;
									tx_word <= reg_read(ptr);
									rd_stb <= 1'b1;
									acc_addr <= ptr;
								end else begin
									st <= SL_PTR;
								end
							end else begin
								st <= SL_IDLE;
							end
						end
						SL_PTR: begin
							ptr <= shreg;
							link.sda_dev_oe <= 1'b1;
							st <= SL_WR;
						end
						SL_WR: begin
							link.sda_dev_oe <= 1'b1;
							byte_hi <= !byte_hi;
							if (!byte_hi) begin
								msb_hold <= shreg;
							end else begin
								wr_stb <= 1'b1;
								acc_addr <= ptr;
								wr_data <= {msb_hold, shreg};
								ptr <= ptr + 8'h01;
							end
						end
						default: link.sda_dev_oe <= 1'b0;  // controller acks
					endcase
				end else if (cnt == 4'h9) begin
					cnt <= 4'h0;
					if (st == SL_RD && link.sda_dev_oe) begin
						// address ack done, first bit of the high byte
						link.sda_dev_oe <= !tx_word[15];
					end else if (st == SL_RD && !byte_hi) begin
						byte_hi <= 1'b1;
						link.sda_dev_oe <= !tx_word[7];
					end else if (st == SL_RD) begin
						// next word, auto-increment
						byte_hi <= 1'b0;
						ptr <= ptr + 8'h01;
						tx_word <= next_word;
						rd_stb <= 1'b1;
						acc_addr <= ptr + 8'h01;
						link.sda_dev_oe <= !next_word[15];
					end else begin
						link.sda_dev_oe <= 1'b0;
					end
				end else if (st == SL_RD) begin
					link.sda_dev_oe <= !tx_word[(byte_hi ? 4'h7 : 4'hF) - cnt];
				end
			end
		end
	end

	// writable registers and soft reset pulse
	// config retained in sleep
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			err_mask <= scc_pkg::RST_MASK;
			cfg <= scc_pkg::RST_CONFIG;
			seq_cfg <= scc_pkg::RST_SEQ;
			soft_rst <= 1'b0;
		end else if (dev_clr) begin
			err_mask <= scc_pkg::RST_MASK;
			cfg <= scc_pkg::RST_CONFIG;
			seq_cfg <= scc_pkg::RST_SEQ;
			soft_rst <= 1'b0;
		end else begin
			soft_rst <= wr_stb && acc_addr == scc_pkg::REG_RESET && wr_data[scc_pkg::RST_TRIG_BIT];
			if (wr_stb && acc_addr == scc_pkg::REG_MASK) err_mask <= wr_data;
			if (wr_stb && acc_addr == scc_pkg::REG_CONFIG) cfg <= wr_data;
			if (wr_stb && acc_addr == scc_pkg::REG_SEQ) seq_cfg <= wr_data;
		end
	end

	// wake delay then conversion mode
	// wake delay count
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			wake_cnt <= 15'h0000;
			converting <= 1'b0;
			win_cnt <= 8'h00;
		end else if (sleep_now || dev_clr) begin
			wake_cnt <= 15'h0000;
			converting <= 1'b0;
			win_cnt <= 8'h00;
		end else if (!converting) begin
			wake_cnt <= wake_cnt + 15'h0001;
			converting <= (wake_cnt == 15'(WAKE_CYCLES - 1));
		end else begin
			win_cnt <= win_cnt + 8'h01;
		end
	end

	// per channel sync, glitch filter and edge counting
	// every channel counted each window
	generate
		for (genvar ch = 0; ch < 4; ch++) begin : g_chan
			logic       os1, os2, of_d;
			logic [2:0] gcnt;
			always_ff @(posedge sys_clk or negedge reset_n) begin
				if (!reset_n) begin
					{os1, os2, of_d} <= 3'h0;
					osc_f[ch] <= 1'b0;
					gcnt <= 3'h0;
					edges[ch] <= 12'h000;
					result[ch] <= 12'h000;
				end else begin
					{os1, os2, of_d} <= {sensor_osc[ch], os1, osc_f[ch]};
					if (os2 == osc_f[ch]) begin
						gcnt <= 3'h0;
					end else if (gcnt >= gf_len(seq_cfg[2:0])) begin
						osc_f[ch] <= os2;
						gcnt <= 3'h0;
					end else begin
						gcnt <= gcnt + 3'h1;
					end
					if (sleep_now || dev_clr || !converting) begin
						edges[ch] <= 12'h000;
						if (sleep_now || dev_clr) result[ch] <= 12'h000;
					end else if (win_end) begin
						result[ch] <= edges[ch];
						edges[ch] <= 12'h000;
					end else if (osc_f[ch] && !of_d && edges[ch] != 12'hFFF) begin
						edges[ch] <= edges[ch] + 12'h001;
					end
				end
			end
		end
	endgenerate

	// events of a finished window
	always_comb begin
		ev_bits = 16'h0000;
		if (win_end) begin
			ev_bits[scc_pkg::ST_DRDY_BIT] = 1'b1;
			ev_bits[3:0] = 4'hF;
			for (int i = 3; i >= 0; i--) begin
				if (edges[i] == 12'h000 || edges[i] == 12'hFFF) begin
					ev_bits[15:14] = 2'(i);
				end
			end
			for (int i = 0; i < 4; i++) begin
				if (edges[i] == 12'h000) ev_bits[scc_pkg::ST_UR_BIT] = 1'b1;
				if (edges[i] == 12'hFFF) ev_bits[scc_pkg::ST_OR_BIT] = 1'b1;
			end
		end
	end

	// status capture, freeze and clear
	// held while nonzero
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			status <= scc_pkg::RST_STATUS;
		end else if (dev_clr || sleep_now) begin
			status <= scc_pkg::RST_STATUS;
		end else if (rd_stb && (acc_addr == scc_pkg::REG_STATUS || is_data(acc_addr))) begin
			status <= ev_bits;
		end else if (status == 16'h0000) begin
			status <= ev_bits;
		end
	end

	assign irq_pend = (err_mask[scc_pkg::MSK_UR_BIT] && status[scc_pkg::ST_UR_BIT]) ||
		(err_mask[scc_pkg::MSK_OR_BIT] && status[scc_pkg::ST_OR_BIT]) ||
		(err_mask[scc_pkg::MSK_DRDY_BIT] && status[scc_pkg::ST_DRDY_BIT]);

	// interrupt pin register
	// disable holds pin high
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			link.interrupt_out_low <= 1'b1;
		end else begin
			link.interrupt_out_low <= !(irq_pend && !cfg[scc_pkg::CFG_IRQ_DIS_BIT]);
		end
	end
endmodule // scc_device
`default_nettype wire

// ==== verilog/scc_host.sv ====
// i2c controller end: command registers and bit sequencer
`default_nettype none
module scc_host (
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic [2:0]  cmd_addr,
	input  wire logic [15:0] cmd_wdata,
	input  wire logic        cmd_wr,
	input  wire logic        cmd_rd,
	output logic      [15:0] cmd_rdata,
	scc_link_if.host         link
);
	typedef enum logic [1:0] {K_START = 2'b00, K_TX = 2'b01, K_RX = 2'b10, K_STOP = 2'b11} scc_kind_t;

	logic        busy;         // transfer running
	logic        rw;           // 1 for a register read
	logic [7:0]  ptr;          // target register
	logic [15:0] wdata;        // word to write
	logic [15:0] rdata;        // word read back
	logic        nack;         // last transfer refused
	logic [2:0]  step;         // position in the script
	logic [3:0]  bitn;         // bit in byte, 8 is ack
	logic [1:0]  q;            // quarter of a bit
	logic [7:0]  qcnt;         // quarter divider
	logic        tick;         // quarter pulse
	logic        sda_s1, sda_s2, irq_s1, irq_s2;
	logic        shut, asel;
	scc_kind_t   kind;
	logic [7:0]  tbyte;

	// script of one transfer: kind and byte of a step
	function automatic logic [9:0] script(input logic [2:0] s, input logic r);
		logic [6:0] a;
		a = asel ? scc_pkg::ADDR_PIN_HIGH : scc_pkg::ADDR_PIN_LOW;
		case (s)
			3'h0:    script = {K_START, 8'h00};
			3'h1:    script = {K_TX, a, 1'b0};
			3'h2:    script = {K_TX, ptr};
			3'h3:    script = r ? {K_START, 8'h00} : {K_TX, wdata[15:8]};
			3'h4:    script = r ? {K_TX, a, 1'b1} : {K_TX, wdata[7:0]};
			3'h5:    script = r ? {K_RX, 8'h00} : {K_STOP, 8'h00};
			3'h6:    script = {K_RX, 8'h00};
			default: script = {K_STOP, 8'h00};
		endcase
	endfunction

	// re-evaluated on pointer, data and strap changes as well
	always_comb {kind, tbyte} = script(step, rw);
	assign tick = busy && (qcnt == 8'(scc_pkg::I2C_QTR_CYCLES - 1));
	assign link.shutdown_pin = shut;
	assign link.addr_sel = asel;

	// pin synchronisers
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			{sda_s1, sda_s2, irq_s1, irq_s2} <= 4'hF;
		end else begin
			sda_s1 <= link.sda;
			sda_s2 <= sda_s1;
			irq_s1 <= link.interrupt_out_low;
			irq_s2 <= irq_s1;
		end
	end

	// quarter-bit divider keeps scl under the top rate
	// rate limit divider
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			qcnt <= 8'h00;
		end else if (!busy || tick) begin
			qcnt <= 8'h00;
		end else begin
			qcnt <= qcnt + 8'h01;
		end
	end

	// command registers
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rw <= 1'b0;
			ptr <= 8'h00;
			wdata <= 16'h0000;
			shut <= 1'b0;
			asel <= 1'b0;
		end else if (cmd_wr) begin
			case (cmd_addr)
				scc_pkg::HR_CMD: begin
					// ignored while busy
					if (!busy) begin
						rw <= cmd_wdata[scc_pkg::HC_READ_BIT];
						ptr <= cmd_wdata[7:0];
					end
				end
				scc_pkg::HR_WDATA: wdata <= cmd_wdata;
				scc_pkg::HR_PINS: {asel, shut} <= cmd_wdata[1:0];
				default: ;
			endcase
		end
	end

	// read port, data one cycle after strobe
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cmd_rdata <= 16'h0000;
		end else if (cmd_rd) begin
			case (cmd_addr)
				scc_pkg::HR_WDATA: cmd_rdata <= wdata;
				scc_pkg::HR_STAT:  cmd_rdata <= {13'h0000, ~irq_s2, nack, busy};
				scc_pkg::HR_RDATA: cmd_rdata <= rdata;
				scc_pkg::HR_PINS:  cmd_rdata <= {14'h0000, asel, shut};
				default:           cmd_rdata <= 16'h0000;
			endcase
		end else begin
			cmd_rdata <= 16'h0000;
		end
	end

	// bit sequencer, one quarter per tick
	// address then pointer byte
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			busy <= 1'b0;
			step <= 3'h0;
			bitn <= 4'h0;
			q <= 2'h0;
			nack <= 1'b0;
			rdata <= 16'h0000;
			link.scl_host_oe <= 1'b0;
			link.sda_host_oe <= 1'b0;
		end else if (!busy) begin
			// start on a command write
			if (cmd_wr && cmd_addr == scc_pkg::HR_CMD) begin
				busy <= 1'b1;
				nack <= 1'b0;
				step <= 3'h0;
				bitn <= 4'h0;
				q <= 2'h0;
			end
		end else if (tick) begin
			q <= q + 2'h1;
			case (kind)
				K_START: begin
					case (q)
						2'h0: link.sda_host_oe <= 1'b0;
						2'h1: link.scl_host_oe <= 1'b0;
						2'h2: link.sda_host_oe <= 1'b1;
						default: begin
							link.scl_host_oe <= 1'b1;
							step <= step + 3'h1;
						end
					endcase
				end
				K_STOP: begin
					case (q)
						2'h0: link.sda_host_oe <= 1'b1;
						2'h1: link.scl_host_oe <= 1'b0;
						2'h2: link.sda_host_oe <= 1'b0;
						default: busy <= 1'b0;
					endcase
				end
				default: begin
					case (q)
						2'h0: begin
							// drive data, ack the first read byte, nack the last
							if (kind == K_TX) begin
								link.sda_host_oe <= (bitn < 4'h8) && !tbyte[3'(4'h7 - bitn)];
							end else begin
								link.sda_host_oe <= (bitn == 4'h8) && (step == 3'h5);
							end
						end
						2'h1: link.scl_host_oe <= 1'b0;
						2'h2: begin
							if (kind == K_TX && bitn == 4'h8 && sda_s2) begin
								nack <= 1'b1;
							end else if (kind == K_RX && bitn < 4'h8) begin
								rdata <= {rdata[14:0], sda_s2};
							end
						end
						default: begin
							link.scl_host_oe <= 1'b1;
							if (bitn == 4'h8) begin
								bitn <= 4'h0;
								// a refused byte goes straight to stop
								step <= nack ? 3'h7 : step + 3'h1;
							end else begin
								bitn <= bitn + 4'h1;
							end
						end
					endcase
				end
			endcase
		end
	end
endmodule // scc_host
`default_nettype wire

// ==== verilog/scc_link_if.sv ====
// open-drain i2c pins plus sideband pins between host and device
`default_nettype none
interface scc_link_if;
	logic scl_host_oe;        // host pulls scl low
	logic sda_host_oe;        // host pulls sda low
	logic sda_dev_oe;         // device pulls sda low
	logic shutdown_pin;       // high puts device in shutdown
	logic addr_sel;           // address select strap
	logic interrupt_out_low;  // active-low interrupt
	logic scl;                // resolved wire levels
	logic sda;
	// wired-and with pull-ups
	assign scl = ~scl_host_oe;
	assign sda = ~(sda_host_oe | sda_dev_oe);
	modport host (output scl_host_oe, output sda_host_oe, output shutdown_pin,
		output addr_sel, input scl, input sda, input interrupt_out_low);
	modport device (output sda_dev_oe, output interrupt_out_low, input scl,
		input sda, input shutdown_pin, input addr_sel);
endinterface
`default_nettype wire

// ==== verilog/scc_pkg.sv ====
// constants shared by both ends of the sensor converter control link
`default_nettype none
package scc_pkg;
	// clocking and link rate
	localparam int unsigned SYS_CLK_HZ     = 10_000_000;  // sys_clk rate
	localparam int unsigned I2C_MAX_BPS    = 400_000;     // top bit rate
	localparam int unsigned I2C_QTR_CYCLES =              // quarter bit, rounded up
		(SYS_CLK_HZ + 4 * I2C_MAX_BPS - 1) / (4 * I2C_MAX_BPS);
	localparam int unsigned WAKE_REF_CYCLES = 16384;      // wake delay, ref clocks
	localparam int unsigned CONV_CYCLES     = 256;        // one conversion window

	// slave addresses
	localparam logic [6:0] ADDR_PIN_LOW  = 7'h2A;
	localparam logic [6:0] ADDR_PIN_HIGH = 7'h2B;

	// device register pointers
	localparam logic [7:0] REG_DATA0  = 8'h00;
	localparam logic [7:0] REG_DATA1  = 8'h02;
	localparam logic [7:0] REG_DATA2  = 8'h04;
	localparam logic [7:0] REG_DATA3  = 8'h06;
	localparam logic [7:0] REG_STATUS = 8'h18;
	localparam logic [7:0] REG_MASK   = 8'h19;
	localparam logic [7:0] REG_CONFIG = 8'h1A;
	localparam logic [7:0] REG_SEQ    = 8'h1B;
	localparam logic [7:0] REG_RESET  = 8'h1C;

	// reset values
	localparam logic [15:0] RST_STATUS = 16'h0000;
	localparam logic [15:0] RST_MASK   = 16'h0000;
	localparam logic [15:0] RST_CONFIG = 16'h2801;
	localparam logic [15:0] RST_SEQ    = 16'h020F;

	// field positions
	localparam int unsigned CFG_SLEEP_BIT   = 13;  // sleep request
	localparam int unsigned CFG_IRQ_DIS_BIT = 7;   // irq_output_disable
	localparam int unsigned RST_TRIG_BIT    = 15;  // soft_reset_trigger
	localparam int unsigned ST_CHAN_LSB     = 14;  // error_channel_id [15:14]
	localparam int unsigned ST_UR_BIT       = 13;  // under-range
	localparam int unsigned ST_OR_BIT       = 12;  // over-range
	localparam int unsigned ST_DRDY_BIT     = 6;   // data ready
	localparam int unsigned MSK_UR_BIT      = 15;
	localparam int unsigned MSK_OR_BIT      = 14;
	localparam int unsigned MSK_DRDY_BIT    = 0;

	// glitch filter codes
	localparam logic [2:0] GF_1MHZ  = 3'h1;
	localparam logic [2:0] GF_3M3HZ = 3'h4;
	localparam logic [2:0] GF_10MHZ = 3'h5;
	localparam logic [2:0] GF_33MHZ = 3'h3;

	// host command port offsets
	localparam logic [2:0] HR_CMD   = 3'h0;
	localparam logic [2:0] HR_WDATA = 3'h1;
	localparam logic [2:0] HR_STAT  = 3'h2;
	localparam logic [2:0] HR_RDATA = 3'h3;
	localparam logic [2:0] HR_PINS  = 3'h4;
	localparam int unsigned HC_READ_BIT = 8;
endpackage
`default_nettype wire
